/* sprc_pkg.sv */
// Shared types and constants for the system power and reset control block
package sprc_pkg;

   // Power sequencing states
   typedef enum logic [1:0] {
      SPRC_OFF,
      SPRC_ON,
      SPRC_SHUTDOWN
   } sprc_state_type;

   // Input pins from the system power supply, the on button and the core reset, sampled together
   typedef struct packed {
      logic power_good;
      logic supply_alert;
      logic transient_rail;
      logic on_button;
      logic core_reset_req;
   } sprc_pins_type;

   // Events reported to software
   typedef struct packed {
      logic power_fail;
      logic alert;
   } sprc_events_type;

   localparam logic [1:0] SPRC_SYNC_INIT = 2'h0;
   localparam sprc_pins_type SPRC_PINS_RESET = '{power_good: 1'b0, supply_alert: 1'b0,
      transient_rail: 1'b0, on_button: 1'b0, core_reset_req: 1'b1};

   // Cycles the supply gets to raise the transient rail before a fault is flagged
   localparam int SPRC_SETTLE_W = 5;
   localparam logic [SPRC_SETTLE_W-1:0] SPRC_RAIL_SETTLE = 5'h10;
   localparam logic [SPRC_SETTLE_W-1:0] SPRC_SETTLE_ONE = 5'h01;
   localparam int SPRC_PIN_COUNT = $bits(sprc_pins_type);

endpackage : sprc_pkg

/* sprc_control.sv */
// System power and reset sequencing logic in the always-on standby domain
//
// What this block does
// [R1] The core reset input resets only the processor core, never this standby logic.
// [R2] The power-on reset input is held low by the outside until standby power is stable.
// [R3] The power-on reset input is not driven low again unless all power is lost.
// [R4] A press of the on button sets the supply chip select to switch the system on.
// [R5] While power good is low the chip select is not asserted from off, for button and wake alike.
// [R6] The supply turns on the memory and transient rails when the chip select asserts.
// [R7] The supply captures serial commands on the chip select falling edge.
// [R8] A fall of power good while the system is on raises a high-priority event at once.
// [R9] The supply alert input becomes a low-priority event for software to read status.
// [R10] The supply raises transient rail status with the chip select, drops it on power-down.
// [R11] The memory rail is off at first standby power and stays off until the first power-up.
// [R12] The chip select stays asserted until software commands power-down, then releases.
`timescale 1ns/100ps
module sprc_control (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic core_reset_n,
   input wire logic on_button_in,
   input wire logic power_good_in,
   input wire logic supply_alert_in,
   input wire logic transient_rail_status,
   input wire logic wake_request,
   input wire logic shutdown_request,
   input wire logic cmd_frame_done,
   input wire logic event_ack,
   output logic supply_chip_select,
   output logic core_reset_out_n,
   output logic power_fail_event,
   output logic alert_event,
   output logic system_on,
   output logic rail_fault
);
   import sprc_pkg::*;

   sprc_pins_type pins_raw;
   sprc_pins_type sync1_q;
   sprc_pins_type sync2_q;
   sprc_pins_type prev_q;
   // Sequencer state lives in the standby domain and survives rails off
   sprc_state_type state_q;
   sprc_state_type state_d;
   sprc_events_type events_q;
   sprc_events_type events_d;
   logic cs_q;
   logic cs_d;
   logic core_rst_q;
   logic core_rst_d;
   logic fault_q;
   logic fault_d;
   // Registered copy of the on state, so the output comes from a flop
   logic system_on_q;
   logic system_on_d;
   // Settle counter for the transient rail check
   logic [SPRC_SETTLE_W-1:0] settle_q;
   logic [SPRC_SETTLE_W-1:0] settle_d;
   logic settled;
   // Decoded edges of the synchronised pins
   logic pg_fall;
   logic alert_rise;

   // Edge decode shared by both event sources; the reference stage resets to
   // the idle level of each pin, so no false edge follows reset
   function automatic logic sprc_edge(
      input logic now_v,
      input logic then_v
   );
      return now_v && !then_v;
   endfunction : sprc_edge

   assign pins_raw = '{power_good: power_good_in, supply_alert: supply_alert_in,
      transient_rail: transient_rail_status, on_button: on_button_in,
      core_reset_req: core_reset_n};

   // Edges are taken between the second and the third stage
   assign pg_fall = sprc_edge(prev_q.power_good, sync2_q.power_good);
   assign alert_rise = sprc_edge(sync2_q.supply_alert, prev_q.supply_alert);
   assign settled = (settle_q == SPRC_RAIL_SETTLE);
   assign system_on_d = (state_d != SPRC_OFF);

   // Two-stage synchroniser per pin; only the second stage feeds logic.
   // The third stage is the edge reference and reads only the second, so a
   // metastable first stage never reaches a decision.
   genvar gi;
   generate
      for (gi = 0; gi < SPRC_PIN_COUNT; gi++) begin : g_sync
         // Reset values are the idle levels of the pins
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin // R2 R3
               sync1_q[gi] <= SPRC_PINS_RESET[gi];
               sync2_q[gi] <= SPRC_PINS_RESET[gi];
               prev_q[gi] <= SPRC_PINS_RESET[gi];
            end else begin
               sync1_q[gi] <= pins_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               prev_q[gi] <= sync2_q[gi];
            end
         end
      end
   endgenerate

   // Sequencer: the chip select is standby state, so it outlives the rails being off
   always_comb begin
      state_d = state_q;
      cs_d = cs_q;
      case (state_q)
         SPRC_OFF: begin
            cs_d = 1'b0; // R11
            // Button and wake are both refused unless power good is seen
            if ((sync2_q.on_button || wake_request) && sync2_q.power_good) begin // R4 R5
               state_d = SPRC_ON;
               cs_d = 1'b1; // R6
            end
         end
         SPRC_ON: begin
            // Power good dropping here does not drop the select; software must
            // shut down first, so commands can still reach the supply
            if (shutdown_request) begin // R12
               state_d = SPRC_SHUTDOWN;
            end
         end
         SPRC_SHUTDOWN: begin
            // Hold the select until the last command is fully shifted, so the
            // falling edge that the supply latches on carries a whole frame
            if (cmd_frame_done) begin // R7 R12
               state_d = SPRC_OFF;
               cs_d = 1'b0;
            end
         end
         default: begin
            state_d = SPRC_OFF;
            cs_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= SPRC_OFF;
         cs_q <= 1'b0;
         system_on_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cs_q <= cs_d;
         // Registered from the next state so it moves with the select
         system_on_q <= system_on_d;
      end
   end

   // Sticky events; a new event in the acknowledge cycle wins over the clear
   always_comb begin
      events_d = events_q;
      if (event_ack) begin
         events_d = '0;
      end
      // Only a running system can lose good power in a way that matters
      if (state_q != SPRC_OFF && pg_fall) begin
         events_d.power_fail = 1'b1; // R8
      end
      // Alert is edge-reported; software reads the changed status back itself
      if (alert_rise) begin
         events_d.alert = 1'b1; // R9
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         events_q <= '0;
      end else begin
         events_q <= events_d;
      end
   end

   // Core reset is kept apart from the standby state above: it only follows the
   // switch and never touches the sequencer or the events.
   // A hung core is recovered by the switch without losing the rails.
   always_comb begin
      core_rst_d = sync2_q.core_reset_req; // R1
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         core_rst_q <= 1'b0;
      end else begin
         core_rst_q <= core_rst_d; // R1
      end
   end

   // Rail check: the supply ramps slowly, so the status is only judged once the
   // settle count has run out after power-up. A supply slower than the count
   // shows a fault for a while; it is a flag only and does not stop the system.
   always_comb begin
      settle_d = settle_q;
      if (state_q != SPRC_ON) begin
         settle_d = '0;
      end else if (!settled) begin
         settle_d = SPRC_SETTLE_W'(settle_q + SPRC_SETTLE_ONE);
      end
      fault_d = (state_q == SPRC_ON) && settled && !sync2_q.transient_rail; // R10
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         settle_q <= '0;
         fault_q <= 1'b0;
      end else begin
         settle_q <= settle_d;
         fault_q <= fault_d;
      end
   end

   // All outputs are plain copies of registers

   assign supply_chip_select = cs_q;
   assign core_reset_out_n = core_rst_q;
   assign power_fail_event = events_q.power_fail;
   assign alert_event = events_q.alert;
   assign system_on = system_on_q;
   assign rail_fault = fault_q;

endmodule : sprc_control

/* sprc_control_chk.sv */
// Port assertions for the power and reset control block
`timescale 1ns/100ps
module sprc_control_chk (
   input logic core_clk,
   input logic resetn,
   input logic core_reset_n,
   input logic on_button_in,
   input logic power_good_in,
   input logic supply_alert_in,
   input logic transient_rail_status,
   input logic shutdown_request,
   input logic cmd_frame_done,
   input logic event_ack,
   input logic supply_chip_select,
   input logic system_on,
   input logic core_reset_out_n,
   input logic power_fail_event,
   input logic alert_event,
   input logic rail_fault
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_cmd; shutdown_request ##1 cmd_frame_done; endsequence
   sequence s_rail_up; (system_on && transient_rail_status) [*3]; endsequence
   a_sel_gate: assert property ($rose(supply_chip_select) |-> $past(power_good_in, 3))
      else $error("select without good");
   a_btn_on: assert property ($rose(on_button_in) && power_good_in
      |-> ##[2:4] supply_chip_select) else $error("button");
   a_sel_on: assert property (supply_chip_select |-> system_on) else $error("on");
   a_sel_free: assert property (s_cmd |=> !supply_chip_select) else $error("free");
   a_fail_evt: assert property ($fell(power_good_in) && system_on
      |-> ##[3:5] power_fail_event) else $error("fail");
   a_fail_keep: assert property (power_fail_event && !event_ack |=> power_fail_event)
      else $error("sticky");
   a_alert_evt: assert property ($rose(supply_alert_in) |-> ##[2:5] alert_event)
      else $error("alert");
   a_core_rst: assert property ($fell(core_reset_n) |-> ##[2:4] !core_reset_out_n)
      else $error("core");
   a_rail_ok: assert property (s_rail_up |=> !rail_fault)
      else $error("rail fault with rail up");
endmodule : sprc_control_chk

/* sprc_supply_model.sv */
// Behavioural system power supply
`timescale 1ns/100ps
module sprc_supply_model (
   input logic supply_chip_select,
   input logic good,
   output logic power_good_in,
   output logic transient_rail_status
);
   logic memory_rail = 1'b0;
   int cmds = 0;
   assign power_good_in = good;
   initial transient_rail_status = 1'b0;
   // Slow rail: status lags the select by eight cycles
   always @(supply_chip_select) transient_rail_status <= #40 supply_chip_select;
   always @(posedge supply_chip_select) memory_rail <= 1'b1;
   always @(negedge supply_chip_select) cmds++;
endmodule : sprc_supply_model

/* sprc_control_tb.sv */
// Self-checking bench for the power and reset control block
`timescale 1ns/100ps
`define CHK(a,b) checks_done++; if ((a)!==(b)) begin fail_count++; $display("FAIL %0t %h %h",$time,a,b); end
module sprc_control_tb;
   logic core_clk = 0, resetn = 0, core_reset_n = 1, on_button_in = 0, supply_alert_in = 0;
   logic wake_request = 0, shutdown_request = 0, cmd_frame_done = 0, event_ack = 0, good = 0;
   logic supply_chip_select, core_reset_out_n, power_fail_event, alert_event, system_on;
   logic rail_fault, power_good_in, transient_rail_status;
   logic [2:0] last_q = 3'h0, e, exp_q[$];
   logic [15:0] lfsr = 16'h70f6;
   int fail_count = 0, checks_done = 0;
   wire [2:0] obs = {supply_chip_select, power_fail_event, alert_event};
   always #2.5 core_clk = ~core_clk;
   sprc_control uut (
      .core_clk(core_clk),
      .resetn(resetn),
      .core_reset_n(core_reset_n),
      .on_button_in(on_button_in),
      .power_good_in(power_good_in),
      .supply_alert_in(supply_alert_in),
      .transient_rail_status(transient_rail_status),
      .wake_request(wake_request),
      .shutdown_request(shutdown_request),
      .cmd_frame_done(cmd_frame_done),
      .event_ack(event_ack),
      .supply_chip_select(supply_chip_select),
      .core_reset_out_n(core_reset_out_n),
      .power_fail_event(power_fail_event),
      .alert_event(alert_event),
      .system_on(system_on),
      .rail_fault(rail_fault)
   );
   sprc_supply_model sup (
      .supply_chip_select(supply_chip_select),
      .good(good),
      .power_good_in(power_good_in),
      .transient_rail_status(transient_rail_status)
   );
   function automatic logic [15:0] nxt(logic [15:0] v); return {v[14:0], ^(v & 16'hb400)};
   endfunction : nxt
   task automatic cyc(int n); repeat (n) @(posedge core_clk); #1; endtask : cyc
   task automatic gap; lfsr = nxt(lfsr); cyc(6 + lfsr[2:0]); endtask : gap
   task automatic pulse(ref logic s, input int n); s = 1; cyc(n); s = 0; gap; endtask : pulse
   task automatic off; shutdown_request = 1; cyc(1); shutdown_request = 0; cmd_frame_done = 1;
      cyc(1); cmd_frame_done = 0; gap; endtask : off
   // Any change of the watched outputs consumes the oldest expectation
   always @(negedge core_clk) if (resetn && obs !== last_q) begin
      last_q = obs;
      e = exp_q.size() ? exp_q.pop_front() : 3'hx;
      `CHK(last_q, e)
   end
   initial begin
      cyc(5); resetn = 1; gap;
      `CHK(sup.memory_rail, 1'b0)
      pulse(on_button_in, 4);
      pulse(wake_request, 2);
      good = 1; gap;
      exp_q = {exp_q, 3'h4, 3'h5, 3'h4, 3'h0};
      if (lfsr[0]) pulse(on_button_in, 4); else pulse(wake_request, 2);
      cyc(20);
      `CHK(transient_rail_status, 1'b1)
      `CHK(sup.memory_rail, 1'b1)
      `CHK(rail_fault, 1'b0)
      pulse(supply_alert_in, 3);
      pulse(event_ack, 1);
      off;
      `CHK(sup.cmds, 1)
      $display("power up test done");
      exp_q = {exp_q, 3'h4, 3'h6, 3'h2, 3'h0};
      pulse(on_button_in, 4);
      good = 0; gap;
      off;
      pulse(event_ack, 1);
      core_reset_n = 0;
      pulse(wake_request, 6);
      `CHK(core_reset_out_n, 1'b0)
      `CHK(supply_chip_select, 1'b0)
      core_reset_n = 1;
      cyc(4);
      `CHK(core_reset_out_n, 1'b1)
      $display("power fail test done");
      end_sim;
   end
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0 && exp_q.size() == 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   initial begin #20000; fail_count++; end_sim; end
endmodule : sprc_control_tb
bind sprc_control sprc_control_chk chk (.*);
